// *** pkg/bsp_regs.svh ***
// named constants of the sensorless bldc control and protection block
`ifndef BSP_REGS_SVH
`define BSP_REGS_SVH
`define BSP_CLK_HZ        100000000
`define BSP_CARRIER_US    100
`define BSP_TICK_US       1000
`define BSP_TMR_HZ        93750
`define BSP_RPM_NUM       (60 * `BSP_TMR_HZ / 6)
`define BSP_PI_MS         5
`define BSP_TIMEOUT_MS    20
`define BSP_OVERSPEED_RPM 16'h80E8
`define BSP_VDC_FULL_MV   26000
`define BSP_ADC_FULL      10'h3FF
`define BSP_OV_MV         24000
`define BSP_OV_CODE       (`BSP_OV_MV * 1023 / `BSP_VDC_FULL_MV)
`define BSP_GAIN_Q        16'hA7C6
`define BSP_GAIN_FRAC     32
`define BSP_VMAX_V        26
`define BSP_DEBOUNCE_MS   20
`define BSP_LONG_MS       1000
`define BSP_SPD_MIN       16'h0FA0
`define BSP_SPD_MAX       16'h7530
`define BSP_SPD_STEP      16'h07D0
`define BSP_PIN_IDLE      7'h70
`define BSP_PAT_NONE      3'h0
`define BSP_PAT_ALL       3'h7
`define BSP_E_PRE         0
`define BSP_E_OC          1
`define BSP_E_OS          2
`define BSP_E_TO          3
`define BSP_E_PAT         4
`define BSP_E_OV          5
`define BSP_E_W           6
`endif

// *** pkg/bsp_pkg.sv ***
// types of the sensorless bldc control and protection block
`default_nettype none
package bsp_pkg;
    typedef enum logic [0:0] {BSP_IDLE, BSP_RUN} bsp_run_t;
    typedef logic [15:0] bsp_rpm_t;
    typedef logic [2:0]  bsp_pat_t;
endpackage : bsp_pkg
`default_nettype wire

// *** rtl/bsp_divider.sv ***
// serial restoring divider used for the speed calculation
`default_nettype none
module bsp_divider #(
    parameter int NW = 20,
    parameter int DW = 16
) (
    input  wire logic          clock,
    input  wire logic          reset,
    input  wire logic          start,
    input  wire logic [NW-1:0] numer,
    input  wire logic [DW-1:0] denom,
    output logic               done,
    output logic [NW-1:0]      quot
);
    localparam int CW = $clog2(NW + 1);
    logic [DW:0]   rem_ff;
    logic [NW-1:0] q_ff;
    logic [DW-1:0] den_ff;
    logic [CW-1:0] cnt_ff;
    logic          busy_ff;
    logic          done_ff;
    // one quotient bit per cycle; a zero divisor yields all ones
    wire logic [DW:0] trial = {rem_ff[DW-1:0], q_ff[NW-1]};
    wire logic        fits  = trial >= {1'b0, den_ff};

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rem_ff  <= '0;
            q_ff    <= '0;
            den_ff  <= '0;
            cnt_ff  <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (start) begin
                rem_ff  <= '0;
                q_ff    <= numer;
                den_ff  <= denom;
                cnt_ff  <= CW'(NW);
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                rem_ff <= fits ? trial - {1'b0, den_ff} : trial;
                q_ff   <= {q_ff[NW-2:0], fits};
                cnt_ff <= cnt_ff - CW'(1);
                if (cnt_ff == CW'(1)) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
            end
        end
    end

    assign done = done_ff;
    assign quot = q_ff;
endmodule : bsp_divider
`default_nettype wire

// *** rtl/bsp_core.sv ***
// sensorless 120 degree bldc commutation, speed control and protection
`include "bsp_regs.svh"
`default_nettype none
module bsp_core #(
    parameter int CARRIER_CYC = `BSP_CLK_HZ / 1000000 * `BSP_CARRIER_US,
    parameter int TICK_CYC    = `BSP_CLK_HZ / 1000000 * `BSP_TICK_US,
    parameter int DEBOUNCE_MS = `BSP_DEBOUNCE_MS,
    parameter int LONG_MS     = `BSP_LONG_MS,
    parameter int AVG_LOG     = 2
) (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       startStopButtonN,
    input  wire logic       predriverFaultA,
    input  wire logic       predriverFaultB,
    input  wire logic       overcurrentIrq,
    input  wire logic       cmpU,
    input  wire logic       cmpV,
    input  wire logic       cmpW,
    input  wire logic [9:0] busVoltage,
    input  wire logic       busVoltageValid,
    input  wire logic       clearErrors,
    output logic [5:0]      phaseDrive,
    output logic [5:0]      driveOeN,
    output logic            motorRunning,
    output bsp_pkg::bsp_rpm_t speedCmd,
    output bsp_pkg::bsp_rpm_t speedRpm,
    output logic [15:0]     voltageCmd,
    output logic [9:0]      busVoltageHeld,
    output logic [5:0]      errorFlags
);
    import bsp_pkg::*;
    localparam int CCW = $clog2(CARRIER_CYC);
    localparam int MCW = $clog2(TICK_CYC);
    localparam int DBW = $clog2(DEBOUNCE_MS + 1);
    localparam int HW  = $clog2(LONG_MS + 1);
    localparam int AN  = 1 << AVG_LOG;
    localparam logic [26:0] TMR_INC = 27'(`BSP_TMR_HZ);
    localparam logic [26:0] CLK_MOD = 27'(`BSP_CLK_HZ);
    localparam logic signed [47:0] VMAX_Q = 48'(`BSP_VMAX_V) <<< `BSP_GAIN_FRAC;

    //--------------------------------------------------------------
    // pin synchronisers
    //--------------------------------------------------------------
    logic [6:0] pinMeta_ff;
    logic [6:0] pinSync_ff;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pinMeta_ff <= `BSP_PIN_IDLE;
            pinSync_ff <= `BSP_PIN_IDLE;
        end else begin
            pinMeta_ff <= {startStopButtonN, predriverFaultA, predriverFaultB,
                           overcurrentIrq, cmpU, cmpV, cmpW};
            pinSync_ff <= pinMeta_ff;
        end
    end
    wire logic     rawPress = !pinSync_ff[6];
    wire logic     faultA   = pinSync_ff[5];
    wire logic     faultB   = pinSync_ff[4];
    wire logic     ocSync   = pinSync_ff[3];
    wire bsp_pat_t cmpPat   = pinSync_ff[2:0];

    //--------------------------------------------------------------
    // tick dividers and free-running capture timer
    //--------------------------------------------------------------
    logic [CCW-1:0] carCnt_ff;
    logic [MCW-1:0] msCnt_ff;
    logic [26:0]    phase_ff;
    logic [15:0]    timer_ff;
    wire logic carrierTick = carCnt_ff == CCW'(CARRIER_CYC - 1);
    wire logic msTick      = msCnt_ff == MCW'(TICK_CYC - 1);
    wire logic [26:0] phaseSum = phase_ff + TMR_INC;
    wire logic tmrEn = phaseSum >= CLK_MOD;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            carCnt_ff <= '0;
            msCnt_ff  <= '0;
            phase_ff  <= '0;
            timer_ff  <= '0;
        end else begin
            carCnt_ff <= carrierTick ? '0 : carCnt_ff + CCW'(1);
            msCnt_ff  <= msTick ? '0 : msCnt_ff + MCW'(1);
            phase_ff  <= tmrEn ? phaseSum - CLK_MOD : phaseSum;
            if (tmrEn) timer_ff <= timer_ff + 16'h0001;
        end
    end

    //--------------------------------------------------------------
    // button debounce and press classification, sampled each 1 ms
    //--------------------------------------------------------------
    logic           btnDown_ff;
    logic [DBW-1:0] dbCnt_ff;
    logic [HW-1:0]  holdCnt_ff;
    wire logic dbFlip = msTick && rawPress != btnDown_ff
                        && dbCnt_ff == DBW'(DEBOUNCE_MS - 1);
    // a release on the very tick that reaches the long threshold counts as long
    wire logic shortPress = dbFlip && btnDown_ff && holdCnt_ff < HW'(LONG_MS - 1);
    wire logic longPress  = msTick && btnDown_ff
                            && holdCnt_ff == HW'(LONG_MS - 1);
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            btnDown_ff <= 1'b0;
            dbCnt_ff   <= '0;
            holdCnt_ff <= '0;
        end else if (msTick) begin
            dbCnt_ff   <= (rawPress == btnDown_ff || dbFlip) ? '0 : dbCnt_ff + DBW'(1);
            btnDown_ff <= dbFlip ? rawPress : btnDown_ff;
            if (!btnDown_ff) holdCnt_ff <= '0;
            else if (holdCnt_ff != HW'(LONG_MS)) holdCnt_ff <= holdCnt_ff + HW'(1);
        end
    end

    //--------------------------------------------------------------
    // commutation pattern tracking
    //--------------------------------------------------------------
    function automatic bsp_pat_t nextPat(input bsp_pat_t p);
        case (p)
            3'h1:    nextPat = 3'h3;
            3'h3:    nextPat = 3'h2;
            3'h2:    nextPat = 3'h6;
            3'h6:    nextPat = 3'h4;
            3'h4:    nextPat = 3'h5;
            3'h5:    nextPat = 3'h1;
            default: nextPat = `BSP_PAT_NONE;
        endcase
    endfunction : nextPat

    // gate order up un vp vn wp wn
    function automatic logic [5:0] gateMap(input bsp_pat_t p);
        case (p)
            3'h1:    gateMap = 6'h24;
            3'h3:    gateMap = 6'h21;
            3'h2:    gateMap = 6'h09;
            3'h6:    gateMap = 6'h18;
            3'h4:    gateMap = 6'h12;
            3'h5:    gateMap = 6'h06;
            default: gateMap = 6'h00;
        endcase
    endfunction : gateMap

    bsp_run_t    state_ff;
    bsp_run_t    nxt_state;
    logic        motorRun_ff;
    bsp_pat_t    curPat_ff;
    logic [15:0] lastCap_ff;
    logic [15:0] diff_ff;
    logic        divStart_ff;
    wire logic patBad   = cmpPat == `BSP_PAT_NONE || cmpPat == `BSP_PAT_ALL;
    wire logic patMoved = motorRun_ff && carrierTick && cmpPat != curPat_ff;
    wire logic commEv   = patMoved && !patBad
                          && (curPat_ff == `BSP_PAT_NONE || cmpPat == nextPat(curPat_ff));
    wire logic patErr   = motorRun_ff && (patBad || (patMoved && !commEv));

    //--------------------------------------------------------------
    // error detection and latching
    //--------------------------------------------------------------
    logic [5:0]                          errors_ff;
    logic [$clog2(`BSP_TIMEOUT_MS+1)-1:0] toCnt_ff;
    logic [9:0]                          vdc_ff;
    wire logic toErr = msTick && motorRun_ff
                       && toCnt_ff >= 5'(`BSP_TIMEOUT_MS);
    wire logic osErr = msTick && motorRun_ff && speedRpm > `BSP_OVERSPEED_RPM;
    wire logic ovErr = busVoltageValid && busVoltage > 10'(`BSP_OV_CODE);
    wire logic [5:0] errSet = {ovErr, patErr, toErr, osErr, ocSync,
                               !(faultA && faultB)};
    wire logic [5:0] nxt_errors = (clearErrors ? 6'h00 : errors_ff) | errSet;
    wire logic stopNow = |nxt_errors;
    wire logic startReq = shortPress && state_ff == BSP_IDLE;
    wire logic stepReq  = shortPress && state_ff == BSP_RUN;

    always_comb begin
        case (state_ff)
            BSP_IDLE: nxt_state = (startReq && !stopNow) ? BSP_RUN : BSP_IDLE;
            BSP_RUN:  nxt_state = (stopNow || longPress) ? BSP_IDLE : BSP_RUN;
            default:  nxt_state = BSP_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_ff    <= BSP_IDLE;
            motorRun_ff <= 1'b0;
            errors_ff   <= 6'h00;
            vdc_ff      <= 10'h000;
            toCnt_ff    <= '0;
            phaseDrive  <= 6'h00;
            driveOeN    <= 6'h00;
            speedCmd    <= `BSP_SPD_MIN;
        end else begin
            state_ff    <= nxt_state;
            motorRun_ff <= nxt_state == BSP_RUN;
            errors_ff   <= nxt_errors;
            if (busVoltageValid) vdc_ff <= busVoltage;
            if (!motorRun_ff || commEv) toCnt_ff <= '0;
            else if (msTick && toCnt_ff != 5'(`BSP_TIMEOUT_MS)) toCnt_ff <= toCnt_ff + 5'(1);
            phaseDrive <= (motorRun_ff && !stopNow) ? gateMap(curPat_ff) : 6'h00;
            driveOeN   <= {6{nxt_errors[`BSP_E_OC]}};
            if (stepReq) speedCmd <= (speedCmd >= `BSP_SPD_MAX) ? `BSP_SPD_MIN
                                                                : speedCmd + `BSP_SPD_STEP;
        end
    end

    //--------------------------------------------------------------
    // interval capture and speed calculation
    //--------------------------------------------------------------
    logic        divDone;
    logic [19:0] divQuot;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            curPat_ff   <= `BSP_PAT_NONE;
            lastCap_ff  <= 16'h0000;
            diff_ff     <= 16'h0000;
            divStart_ff <= 1'b0;
        end else begin
            divStart_ff <= commEv;
            if (!motorRun_ff) curPat_ff <= `BSP_PAT_NONE;
            else if (commEv) begin
                curPat_ff  <= cmpPat;
                lastCap_ff <= timer_ff;
                diff_ff    <= timer_ff - lastCap_ff;
            end
        end
    end

    bsp_divider #(.NW(20), .DW(16)) uDiv (
        .clock (clock),
        .reset (reset),
        .start (divStart_ff),
        .numer (20'(`BSP_RPM_NUM)),
        .denom (diff_ff),
        .done  (divDone),
        .quot  (divQuot)
    );

    //--------------------------------------------------------------
    // moving average of the speed
    //--------------------------------------------------------------
    logic [15:0]         avgMem [AN];
    logic [AVG_LOG-1:0]  avgIdx_ff;
    logic [15+AVG_LOG:0] avgSum_ff;
    wire logic [15:0] speedRaw = (|divQuot[19:16]) ? 16'hFFFF : divQuot[15:0];
    wire logic [15+AVG_LOG:0] nxt_avgSum = avgSum_ff - (15+AVG_LOG+1)'(avgMem[avgIdx_ff])
                                           + (15+AVG_LOG+1)'(speedRaw);
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < AN; i++) avgMem[i] <= 16'h0000;
            avgIdx_ff <= '0;
            avgSum_ff <= '0;
            speedRpm  <= 16'h0000;
        end else if (!motorRun_ff) begin
            for (int i = 0; i < AN; i++) avgMem[i] <= 16'h0000;
            avgIdx_ff <= '0;
            avgSum_ff <= '0;
            speedRpm  <= 16'h0000;
        end else if (divDone) begin
            avgMem[avgIdx_ff] <= speedRaw;
            avgIdx_ff <= avgIdx_ff + AVG_LOG'(1);
            avgSum_ff <= nxt_avgSum;
            speedRpm  <= nxt_avgSum[15+AVG_LOG:AVG_LOG];
        end
    end

    //--------------------------------------------------------------
    // incremental pi speed controller
    //--------------------------------------------------------------
    logic [2:0]          piCnt_ff;
    logic signed [17:0]  prevErr_ff;
    logic signed [47:0]  acc_ff;
    wire logic piFire = msTick && piCnt_ff == 3'(`BSP_PI_MS - 1);
    wire logic signed [17:0] spdErr = $signed({2'b00, speedCmd}) - $signed({2'b00, speedRpm});
    // kp and ki are equal, so kp*(e - e_prev) + ki*e = gain*(2e - e_prev)
    wire logic signed [19:0] piMix = 20'(spdErr) + 20'(spdErr) - 20'(prevErr_ff);
    wire logic signed [36:0] piTerm = piMix * $signed({1'b0, `BSP_GAIN_Q});
    wire logic signed [47:0] accSum = acc_ff + 48'(piTerm);
    wire logic signed [47:0] accNext = accSum < 0 ? 48'sh0 : (accSum > VMAX_Q ? VMAX_Q : accSum);
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            piCnt_ff   <= 3'h0;
            prevErr_ff <= 18'sh0;
            acc_ff     <= 48'sh0;
            voltageCmd <= 16'h0000;
        end else if (!motorRun_ff) begin
            piCnt_ff   <= 3'h0;
            prevErr_ff <= 18'sh0;
            acc_ff     <= 48'sh0;
            voltageCmd <= 16'h0000;
        end else if (msTick) begin
            piCnt_ff <= piFire ? 3'h0 : piCnt_ff + 3'h1;
            if (piFire) begin
                prevErr_ff <= spdErr;
                acc_ff     <= accNext;
                voltageCmd <= accNext[`BSP_GAIN_FRAC+7 -: 16];
            end
        end
    end

    assign motorRunning   = motorRun_ff;
    assign errorFlags     = errors_ff;
    assign busVoltageHeld = vdc_ff;

    //--------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_capture;
        divStart_ff && diff_ff == $past(timer_ff) - $past(lastCap_ff);
    endsequence
    sequence s_divide;
        ##[1:24] divDone;
    endsequence

    property p_ocHiZ;
        ocSync |=> driveOeN == 6'h3F && errorFlags[`BSP_E_OC];
    endproperty
    a_ocHiZ: assert property (p_ocHiZ) else $error("overcurrent did not float outputs");
    property p_preStop;
        !(faultA && faultB) |=> errorFlags[`BSP_E_PRE] && phaseDrive == 6'h00;
    endproperty
    a_preStop: assert property (p_preStop) else $error("pre-driver fault not stopped");
    property p_ovStop;
        busVoltageValid && busVoltage > 10'(`BSP_OV_CODE)
            |=> errorFlags[`BSP_E_OV] && !motorRunning && phaseDrive == 6'h00;
    endproperty
    a_ovStop: assert property (p_ovStop) else $error("overvoltage not stopped");
    property p_offWhileFlag;
        |errorFlags |-> phaseDrive == 6'h00 && !motorRunning;
    endproperty
    a_offWhileFlag: assert property (p_offWhileFlag) else $error("drive on with flag");
    property p_flagHold;
        errorFlags[`BSP_E_TO] && !clearErrors |=> errorFlags[`BSP_E_TO];
    endproperty
    a_flagHold: assert property (p_flagHold) else $error("error flag lost");
    property p_overspeed;
        msTick && motorRun_ff && speedRpm > `BSP_OVERSPEED_RPM |=> errorFlags[`BSP_E_OS];
    endproperty
    a_overspeed: assert property (p_overspeed) else $error("overspeed missed");
    property p_timeout;
        msTick && motorRun_ff && toCnt_ff >= 5'(`BSP_TIMEOUT_MS)
            |=> errorFlags[`BSP_E_TO] && !motorRunning;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout missed");
    property p_pattern;
        motorRun_ff && patBad |=> errorFlags[`BSP_E_PAT];
    endproperty
    a_pattern: assert property (p_pattern) else $error("bad pattern missed");
    property p_capture;
        commEv |=> s_capture;
    endproperty
    a_capture: assert property (p_capture) else $error("interval capture wrong");
    property p_speedCalc;
        divStart_ff |-> s_divide;
    endproperty
    a_speedCalc: assert property (p_speedCalc) else $error("speed not computed");
    property p_piSpace;
        piFire |=> !piFire [*8];
    endproperty
    a_piSpace: assert property (p_piSpace) else $error("pi ran too often");
    property p_longStop;
        longPress |=> !motorRunning;
    endproperty
    a_longStop: assert property (p_longStop) else $error("long press did not stop");
endmodule : bsp_core
`default_nettype wire

// *** testbench/bsp_motor_model.sv ***
// behavioural pre-driver, bridge and motor seen from the control block
`default_nettype none
module bsp_motor_model #(
    parameter int STEP_CYC = 60
) (
    input  wire logic       clock,
    input  wire logic       spin,
    input  wire logic [1:0] faultCode,
    input  wire logic       ocReq,
    input  wire logic       badPat,
    input  wire logic [5:0] phaseDrive,
    input  wire logic [5:0] driveOeN,
    output logic            cmpU,
    output logic            cmpV,
    output logic            cmpW,
    output logic            predriverFaultA,
    output logic            predriverFaultB,
    output logic            overcurrentIrq
);
    import bsp_pkg::*;
    // ----------------------------------------
    // rotor position and back-emf comparators
    // ----------------------------------------
    bsp_pat_t seqTab [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    int       idx = 0;
    int       cnt = 0;
    bsp_pat_t pat;
    // rotor turns only when asked to spin and the bridge is driven and enabled
    always @(posedge clock) begin
        if (spin && (|phaseDrive) && !(|driveOeN)) begin
            cnt <= (cnt >= STEP_CYC - 1) ? 0 : cnt + 1;
            if (cnt >= STEP_CYC - 1) idx <= (idx + 1) % 6;
        end
    end
    assign pat = badPat ? 3'h7 : seqTab[idx];
    assign {cmpU, cmpV, cmpW} = pat;
    // ----------------------------------------
    // pre-driver fault lines and overcurrent
    // ----------------------------------------
    assign {predriverFaultA, predriverFaultB} = faultCode;
    assign overcurrentIrq = ocReq;
endmodule : bsp_motor_model
`default_nettype wire

// *** testbench/bldc_sensorless_speed_protection_test.sv ***
// self-checking bench of the sensorless bldc control and protection block
`default_nettype none
module bldc_sensorless_speed_protection_test;
    timeunit 1ns;
    timeprecision 1ps;
    import bsp_pkg::*;
    localparam int TK = 200;
    typedef struct {int sel; logic [15:0] exp;} bsp_note_t;
    logic clock = 1'b0, reset = 1'b1, btnN = 1'b1, valid = 1'b0, clr = 1'b0;
    logic spin = 1'b0, oc = 1'b0, badPat = 1'b0;
    logic [1:0] fcode = 2'h3;
    logic [9:0] vbus = 10'h000;
    logic cU, cV, cW, fA, fB, ocIrq, running;
    logic [5:0] drv, oeN, flags;
    bsp_rpm_t cmd, rpm;
    logic [15:0] vcmd;
    logic [9:0] held;
    logic [31:0] seed = 32'h6A2E9FF4;
    logic [1:0] codes [3] = '{2'h1, 2'h0, 2'h2};
    int failCount = 0, testsRun = 0;
    bsp_note_t notes [$];
    event chk;
    always #5 clock = ~clock;
    bsp_core #(.CARRIER_CYC(50), .TICK_CYC(TK), .DEBOUNCE_MS(2), .LONG_MS(10), .AVG_LOG(2)) u_dut (
        .clock(clock), .reset(reset), .startStopButtonN(btnN), .predriverFaultA(fA),
        .predriverFaultB(fB), .overcurrentIrq(ocIrq), .cmpU(cU), .cmpV(cV), .cmpW(cW),
        .busVoltage(vbus), .busVoltageValid(valid), .clearErrors(clr), .phaseDrive(drv),
        .driveOeN(oeN), .motorRunning(running), .speedCmd(cmd), .speedRpm(rpm),
        .voltageCmd(vcmd), .busVoltageHeld(held), .errorFlags(flags));
    bsp_motor_model #(.STEP_CYC(60)) u_motor (
        .clock(clock), .spin(spin), .faultCode(fcode), .ocReq(oc), .badPat(badPat),
        .phaseDrive(drv), .driveOeN(oeN), .cmpU(cU), .cmpV(cV), .cmpW(cW),
        .predriverFaultA(fA), .predriverFaultB(fB), .overcurrentIrq(ocIrq));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    task automatic note(input int sel, input logic [15:0] exp);
        notes.push_back('{sel, exp});
        -> chk;
    endtask : note
    task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
        testsRun++;
        if (seen !== exp) begin
            failCount++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : compare
    task automatic press(input int ms);
        btnN = 1'b0;
        cyc(ms * TK);
        btnN = 1'b1;
        cyc(4 * TK);
    endtask : press
    task automatic clear_all();
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(1);
    endtask : clear_all
    task automatic wait_flag(input int b, input int lim);
        int i;
        for (i = 0; i < lim && flags[b] !== 1'b1; i++) cyc(1);
    endtask : wait_flag
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    // ----------------------------------------
    // monitor: oldest note against the outputs
    // ----------------------------------------
    always @(chk) begin
        while (notes.size() > 0) begin
            bsp_note_t n;
            n = notes.pop_front();
            case (n.sel)
                0: compare({10'h000, flags}, n.exp);
                1: compare({15'h0000, running}, n.exp);
                2: compare(cmd, n.exp);
                3: compare({10'h000, oeN}, n.exp);
                4: compare({6'h00, held}, n.exp);
                5: compare(rpm, n.exp);
                6: compare({10'h000, drv}, n.exp);
                default: compare(vcmd, n.exp);
            endcase
        end
    end
    initial begin
        #(200 * TK * 10);
        failCount++;
        give_verdict();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        cyc(4);
        reset = 1'b0;
        cyc(2);
        note(2, 16'h0FA0);
        for (int k = 0; k < 9; k++) begin
            seed = xs(seed);
            vbus = (k == 8) ? 10'h3B0 : 10'(seed % 32'h3B0);
            valid = 1'b1;
            cyc(1);
            valid = 1'b0;
            cyc(2);
            note(4, {6'h00, vbus});
        end
        note(0, 16'h0000);
        vbus = 10'h3B1;
        valid = 1'b1;
        cyc(1);
        valid = 1'b0;
        cyc(2);
        note(0, 16'h0020);
        clear_all();
        foreach (codes[k]) begin
            fcode = codes[k];
            cyc(5);
            note(0, 16'h0001);
            fcode = 2'h3;
            cyc(3);
            clear_all();
        end
        oc = 1'b1;
        cyc(5);
        note(0, 16'h0002);
        note(3, 16'h003F);
        oc = 1'b0;
        cyc(3);
        note(0, 16'h0002);
        clear_all();
        note(3, 16'h0000);
        press(4);
        note(1, 16'h0001);
        // first interval is a count or two: speed saturates, one of four slots filled
        note(5, 16'h3FFF);
        // still rotor at pattern 001 drives up and vn
        note(6, 16'h0024);
        press(4);
        note(2, 16'h1770);
        note(1, 16'h0001);
        // speed above command pulls the command below zero: clamped at zero
        note(7, 16'h0000);
        wait_flag(3, 30 * TK);
        note(0, 16'h0008);
        note(1, 16'h0000);
        clear_all();
        press(4);
        badPat = 1'b1;
        cyc(5);
        note(0, 16'h0010);
        note(1, 16'h0000);
        badPat = 1'b0;
        cyc(3);
        clear_all();
        press(4);
        press(14);
        note(1, 16'h0000);
        note(0, 16'h0000);
        press(4);
        spin = 1'b1;
        wait_flag(2, 20 * TK);
        cyc(2);
        note(0, 16'h0004);
        note(1, 16'h0000);
        spin = 1'b0;
        cyc(2);
        give_verdict();
    end
endmodule : bldc_sensorless_speed_protection_test
`default_nettype wire
